// >>> fm_tx_control_regs_alc.sv
// control register bank, level control and radio data framing
// assumes a serial-bus front end delivering byte writes and reads on clk_sys,
// and a 38 kHz sample strobe and radio data block request from same clock
`timescale 1ns/1ps
module fm_tx_control_regs_alc #(
  parameter int SAMPLE_WIDTH = 16
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic regWrEn,
  input wire logic [6:0] regAddr,
  input wire logic [7:0] regWrData,
  output logic [7:0] regRdData,
  input wire logic sampleStrobe,
  input wire logic [SAMPLE_WIDTH-1:0] leftChannelSamples,
  input wire logic [SAMPLE_WIDTH-1:0] rightChannelSamples,
  input wire logic [7:0] tankCapSetting,
  input wire logic autoTuneActive,
  input wire logic [7:0] autoTankCap,
  input wire logic rdsBlockReq,
  output logic [7:0] clockSetup,
  output logic [12:0] vcoTrimWord,
  output logic [15:0] synthDivider,
  output logic [2:0] leftChannelGain,
  output logic [2:0] rightChannelGain,
  output logic inputAttenuate,
  output logic [3:0] compositeLevelTrim,
  output logic radioDataTxEnable,
  output logic [25:0] rdsBlockWord,
  output logic [1:0] rdsBlockIndex
);
  initial begin
    if (SAMPLE_WIDTH < 16) begin
      $error("sample width below 16 bits is not served");
    end
  end

  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  logic [7:0] clkSetup_ff, nxt_clkSetup;
  logic [7:0] b1Hi_ff, nxt_b1Hi, b1Lo_ff, nxt_b1Lo;
  logic [7:0] ltHi_ff, nxt_ltHi, ltLo_ff, nxt_ltLo;
  logic [7:0] trimLo_ff, nxt_trimLo;
  logic [4:0] trimHi_ff, nxt_trimHi;
  logic [7:0] divStage_ff, nxt_divStage;
  logic [15:0] divider_ff, nxt_divider;
  logic [7:0] alcCtl_ff, nxt_alcCtl, alcRec_ff, nxt_alcRec;
  logic [7:0] alcLim_ff, nxt_alcLim, rdsCtl_ff, nxt_rdsCtl;
  logic [7:0] compTrim_ff, nxt_compTrim;
  logic [7:0] rdData_ff, nxt_rdData;
  logic softReset;

  assign softReset = regWrEn && regAddr == fm_tx_pkg::ADDR_SOFT_RESET &&
                     regWrData == fm_tx_pkg::SOFT_RESET_PATTERN;

  always_comb begin
    nxt_clkSetup = clkSetup_ff;
    nxt_b1Hi = b1Hi_ff;
    nxt_b1Lo = b1Lo_ff;
    nxt_ltHi = ltHi_ff;
    nxt_ltLo = ltLo_ff;
    nxt_trimLo = trimLo_ff;
    nxt_trimHi = trimHi_ff;
    nxt_divStage = divStage_ff;
    nxt_divider = divider_ff;
    nxt_alcCtl = alcCtl_ff;
    nxt_alcRec = alcRec_ff;
    nxt_alcLim = alcLim_ff;
    nxt_rdsCtl = rdsCtl_ff;
    nxt_compTrim = compTrim_ff;
    if (softReset) begin
      nxt_clkSetup = fm_tx_pkg::RST_CLOCK_SETUP;
      nxt_b1Hi = 8'h00;
      nxt_b1Lo = 8'h00;
      nxt_ltHi = 8'h00;
      nxt_ltLo = 8'h00;
      nxt_trimLo = fm_tx_pkg::RST_TRIM_LO;
      nxt_trimHi = fm_tx_pkg::RST_TRIM_HI;
      nxt_divStage = fm_tx_pkg::RST_DIVIDER[7:0];
      nxt_divider = fm_tx_pkg::RST_DIVIDER;
      nxt_alcCtl = fm_tx_pkg::RST_ALC_CTL;
      nxt_alcRec = 8'h00;
      nxt_alcLim = 8'h00;
      nxt_rdsCtl = 8'h00;
      nxt_compTrim = fm_tx_pkg::RST_COMP_TRIM;
    end else if (regWrEn) begin
      unique case (regAddr)
        fm_tx_pkg::ADDR_CLOCK_SETUP: nxt_clkSetup = regWrData;
        fm_tx_pkg::ADDR_RDS_B1_HI: nxt_b1Hi = regWrData;
        fm_tx_pkg::ADDR_RDS_B1_LO: nxt_b1Lo = regWrData;
        fm_tx_pkg::ADDR_RDS_LT_HI: nxt_ltHi = regWrData;
        fm_tx_pkg::ADDR_RDS_LT_LO: nxt_ltLo = regWrData;
        fm_tx_pkg::ADDR_TRIM_LO: nxt_trimLo = regWrData;
        fm_tx_pkg::ADDR_TRIM_HI: nxt_trimHi = regWrData[4:0];
        fm_tx_pkg::ADDR_DIV_LO: nxt_divStage = regWrData;
        fm_tx_pkg::ADDR_DIV_HI: nxt_divider = {regWrData, divStage_ff};
        fm_tx_pkg::ADDR_ALC_CTL: nxt_alcCtl = regWrData;
        fm_tx_pkg::ADDR_ALC_REC: nxt_alcRec = regWrData;
        fm_tx_pkg::ADDR_ALC_LIM: nxt_alcLim = regWrData;
        fm_tx_pkg::ADDR_RDS_CTL: nxt_rdsCtl = regWrData;
        fm_tx_pkg::ADDR_COMP_TRIM: nxt_compTrim = regWrData;
        default: nxt_clkSetup = clkSetup_ff;
      endcase
    end
  end

  always_comb begin
    nxt_rdData = 8'h00;
    unique case (regAddr)
      fm_tx_pkg::ADDR_CLOCK_SETUP: nxt_rdData = clkSetup_ff;
      fm_tx_pkg::ADDR_RDS_B1_HI: nxt_rdData = b1Hi_ff;
      fm_tx_pkg::ADDR_RDS_B1_LO: nxt_rdData = b1Lo_ff;
      fm_tx_pkg::ADDR_RDS_LT_HI: nxt_rdData = ltHi_ff;
      fm_tx_pkg::ADDR_RDS_LT_LO: nxt_rdData = ltLo_ff;
      fm_tx_pkg::ADDR_TRIM_LO: nxt_rdData = trimLo_ff;
      fm_tx_pkg::ADDR_TRIM_HI: nxt_rdData = {3'h0, trimHi_ff};
      fm_tx_pkg::ADDR_DIV_LO: nxt_rdData = divStage_ff;
      fm_tx_pkg::ADDR_DIV_HI: nxt_rdData = divider_ff[15:8];
      fm_tx_pkg::ADDR_ALC_CTL: nxt_rdData = alcCtl_ff;
      fm_tx_pkg::ADDR_ALC_REC: nxt_rdData = alcRec_ff;
      fm_tx_pkg::ADDR_ALC_LIM: nxt_rdData = alcLim_ff;
      fm_tx_pkg::ADDR_RDS_CTL: nxt_rdData = rdsCtl_ff;
      fm_tx_pkg::ADDR_COMP_TRIM: nxt_rdData = compTrim_ff;
      fm_tx_pkg::ADDR_TANK_CAP:
        nxt_rdData = autoTuneActive ? autoTankCap : tankCapSetting;
      default: nxt_rdData = 8'h00;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      clkSetup_ff <= fm_tx_pkg::RST_CLOCK_SETUP;
      b1Hi_ff <= 8'h00;
      b1Lo_ff <= 8'h00;
      ltHi_ff <= 8'h00;
      ltLo_ff <= 8'h00;
      trimLo_ff <= fm_tx_pkg::RST_TRIM_LO;
      trimHi_ff <= fm_tx_pkg::RST_TRIM_HI;
      divStage_ff <= fm_tx_pkg::RST_DIVIDER[7:0];
      divider_ff <= fm_tx_pkg::RST_DIVIDER;
      alcCtl_ff <= fm_tx_pkg::RST_ALC_CTL;
      alcRec_ff <= 8'h00;
      alcLim_ff <= 8'h00;
      rdsCtl_ff <= 8'h00;
      compTrim_ff <= fm_tx_pkg::RST_COMP_TRIM;
      rdData_ff <= 8'h00;
    end else begin
      clkSetup_ff <= nxt_clkSetup;
      b1Hi_ff <= nxt_b1Hi;
      b1Lo_ff <= nxt_b1Lo;
      ltHi_ff <= nxt_ltHi;
      ltLo_ff <= nxt_ltLo;
      trimLo_ff <= nxt_trimLo;
      trimHi_ff <= nxt_trimHi;
      divStage_ff <= nxt_divStage;
      divider_ff <= nxt_divider;
      alcCtl_ff <= nxt_alcCtl;
      alcRec_ff <= nxt_alcRec;
      alcLim_ff <= nxt_alcLim;
      rdsCtl_ff <= nxt_rdsCtl;
      compTrim_ff <= nxt_compTrim;
      rdData_ff <= nxt_rdData;
    end
  end

  assign regRdData = rdData_ff;
  assign clockSetup = clkSetup_ff;
  assign vcoTrimWord = {trimHi_ff, trimLo_ff};
  assign synthDivider = divider_ff;
  assign inputAttenuate = alcLim_ff[fm_tx_pkg::ATTEN_BIT];
  assign compositeLevelTrim = compTrim_ff[fm_tx_pkg::COMP_TRIM_LSB +: 4];

  // ----------------------------------------------------------------
  // automatic level control
  // ----------------------------------------------------------------
  logic alcOn, zcTiming, rightFromLeft, commonGain;
  logic [2:0] manGain;
  logic [14:0] timeoutCnt, holdCnt, periodCnt;
  logic [15:0] limLevel, recLevel;
  logic [15:0] mag [2];
  logic [1:0] sign_ff, nxt_sign;
  logic [2:0] gain_ff [2], nxt_gain [2];
  fm_tx_pkg::pend_e pend_ff [2], nxt_pend [2];
  logic [14:0] stepCnt_ff [2], nxt_stepCnt [2];
  logic [14:0] lowCnt_ff [2], nxt_lowCnt [2];

  assign alcOn = alcCtl_ff[fm_tx_pkg::AUTO_LEVEL_ENABLE_BIT];
  assign manGain = alcCtl_ff[fm_tx_pkg::MAN_GAIN_LSB +: 3];
  assign zcTiming = alcCtl_ff[fm_tx_pkg::TIMING_SEL_BIT];
  assign rightFromLeft = alcCtl_ff[fm_tx_pkg::RIGHT_SRC_BIT];
  assign commonGain = !alcRec_ff[fm_tx_pkg::LINK_SEL_BIT];
  assign timeoutCnt =
    fm_tx_pkg::sel_samples(alcCtl_ff[fm_tx_pkg::TIMEOUT_LSB +: 2]);
  assign holdCnt = fm_tx_pkg::sel_samples(alcRec_ff[fm_tx_pkg::HOLD_LSB +: 2]);
  assign periodCnt = fm_tx_pkg::SAMPLES_2 <<
                     alcLim_ff[fm_tx_pkg::LIM_PERIOD_LSB +: 2];
  assign limLevel = fm_tx_pkg::dbfs_level(fm_tx_pkg::LIM_DB_BASE +
                    {1'b0, alcLim_ff[fm_tx_pkg::LIM_LVL_LSB +: 4]});
  assign recLevel = fm_tx_pkg::dbfs_level(fm_tx_pkg::REC_DB_BASE +
                    {1'b0, alcRec_ff[fm_tx_pkg::REC_LVL_LSB +: 4]});

  always_comb begin
    logic [15:0] lt, rt;
    lt = leftChannelSamples[SAMPLE_WIDTH-1 -: 16];
    rt = rightChannelSamples[SAMPLE_WIDTH-1 -: 16];
    mag[0] = lt[15] ? 16'(~lt + 16'h0001) : lt;
    mag[1] = rt[15] ? 16'(~rt + 16'h0001) : rt;
  end

  always_comb begin
    logic [1:0] curSign, crossed, over, under;
    logic fire, zc;
    fire = 1'b0;
    zc = 1'b0;
    curSign = {rightChannelSamples[SAMPLE_WIDTH-1],
               leftChannelSamples[SAMPLE_WIDTH-1]};
    crossed = curSign ^ sign_ff;
    nxt_sign = sampleStrobe ? curSign : sign_ff;
    over = {mag[1] > limLevel, mag[0] > limLevel};
    under = {mag[1] < recLevel, mag[0] < recLevel};
    // common mode judges both channels on the left path
    if (commonGain) begin
      over = {1'b0, |over};
      under = {1'b0, &under};
    end
    for (int c = 0; c < 2; c++) begin
      nxt_gain[c] = gain_ff[c];
      nxt_pend[c] = pend_ff[c];
      nxt_stepCnt[c] = stepCnt_ff[c];
      nxt_lowCnt[c] = lowCnt_ff[c];
      // right crossings from left when selected
      // zero reference on left in common mode
      zc = (c == 1 && !rightFromLeft && !commonGain) ? crossed[1]
                                                     : crossed[0];
      if (!alcOn) begin
        nxt_gain[c] = fm_tx_pkg::GAIN_UNITY;
        nxt_pend[c] = fm_tx_pkg::PEND_NONE;
        nxt_stepCnt[c] = 15'h0000;
        nxt_lowCnt[c] = 15'h0000;
      end else if (sampleStrobe) begin
        if (under[c] && lowCnt_ff[c] < holdCnt) begin
          nxt_lowCnt[c] = 15'(lowCnt_ff[c] + 15'h0001);
        end else if (!under[c]) begin
          nxt_lowCnt[c] = 15'h0000;
        end
        if (over[c] && gain_ff[c] != 3'h0) begin
          nxt_pend[c] = fm_tx_pkg::PEND_SUPP;
        end else if (pend_ff[c] == fm_tx_pkg::PEND_NONE &&
                     lowCnt_ff[c] >= holdCnt &&
                     gain_ff[c] < fm_tx_pkg::GAIN_MAX) begin
          nxt_pend[c] = fm_tx_pkg::PEND_REC;
        end
        fire = 1'b0;
        if (pend_ff[c] != fm_tx_pkg::PEND_NONE) begin
          nxt_stepCnt[c] = 15'(stepCnt_ff[c] + 15'h0001);
          if (!zcTiming && pend_ff[c] == fm_tx_pkg::PEND_SUPP) begin
            fire = nxt_stepCnt[c] >= periodCnt;
          end else begin
            fire = zc || nxt_stepCnt[c] >= timeoutCnt;
          end
        end
        if (fire) begin
          nxt_stepCnt[c] = 15'h0000;
          if (pend_ff[c] == fm_tx_pkg::PEND_SUPP) begin
            nxt_gain[c] = 3'(gain_ff[c] - 3'h1);
          end else begin
            nxt_gain[c] = 3'(gain_ff[c] + 3'h1);
            nxt_lowCnt[c] = 15'h0000;
          end
          nxt_pend[c] = over[c] && pend_ff[c] == fm_tx_pkg::PEND_SUPP &&
                        gain_ff[c] > 3'h1 ? fm_tx_pkg::PEND_SUPP
                                          : fm_tx_pkg::PEND_NONE;
        end
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      sign_ff <= 2'h0;
      for (int c = 0; c < 2; c++) begin
        gain_ff[c] <= fm_tx_pkg::GAIN_UNITY;
        pend_ff[c] <= fm_tx_pkg::PEND_NONE;
        stepCnt_ff[c] <= 15'h0000;
        lowCnt_ff[c] <= 15'h0000;
      end
    end else begin
      sign_ff <= nxt_sign;
      for (int c = 0; c < 2; c++) begin
        gain_ff[c] <= nxt_gain[c];
        pend_ff[c] <= nxt_pend[c];
        stepCnt_ff[c] <= nxt_stepCnt[c];
        lowCnt_ff[c] <= nxt_lowCnt[c];
      end
    end
  end

  // manual gain when level control is off
  assign leftChannelGain = alcOn ? gain_ff[0] : manGain;
  assign rightChannelGain = !alcOn ? manGain :
                            commonGain ? gain_ff[0] : gain_ff[1];

  // ----------------------------------------------------------------
  // radio data blocks
  // ----------------------------------------------------------------
  logic [25:0] block_ff, nxt_block;
  logic [1:0] blkIdx_ff, nxt_blkIdx;

  assign radioDataTxEnable = rdsCtl_ff[fm_tx_pkg::RADIO_DATA_TX_ENABLE_BIT];

  always_comb begin
    logic [15:0] data;
    logic [9:0] ofs;
    ofs = fm_tx_pkg::OFS_A;
    nxt_block = block_ff;
    nxt_blkIdx = blkIdx_ff;
    data = (blkIdx_ff == 2'h0) ? {b1Hi_ff, b1Lo_ff} : {ltHi_ff, ltLo_ff};
    unique case (blkIdx_ff)
      2'h0: ofs = fm_tx_pkg::OFS_A;
      2'h1: ofs = fm_tx_pkg::OFS_B;
      2'h2: ofs = alcLim_ff[fm_tx_pkg::OFFSET_SEL_BIT] ? fm_tx_pkg::OFS_CP
                                                       : fm_tx_pkg::OFS_C;
      2'h3: ofs = fm_tx_pkg::OFS_D;
    endcase
    if (softReset || !radioDataTxEnable) begin
      nxt_blkIdx = 2'h0;
    end else if (rdsBlockReq) begin
      nxt_blkIdx = 2'(blkIdx_ff + 2'h1);
      if (rdsCtl_ff[fm_tx_pkg::CHECKW_BIT]) begin
        nxt_block = {data, fm_tx_pkg::check_bits(data) ^ ofs};
      end else begin
        nxt_block = {b1Hi_ff, b1Lo_ff, ltHi_ff, ltLo_ff[7:6]};
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      block_ff <= 26'h000_0000;
      blkIdx_ff <= 2'h0;
    end else begin
      block_ff <= nxt_block;
      blkIdx_ff <= nxt_blkIdx;
    end
  end

  assign rdsBlockWord = block_ff;
  assign rdsBlockIndex = blkIdx_ff;
endmodule

// >>> fm_tx_pkg.sv
// constants, field layouts and reset values of the transmitter control bank
// assumes a byte-wide register port fed by the serial-bus front end
//
// Behaviour
// - 13-bit trim word split over two addresses, applied as written
// - divider low byte staged, whole divider loaded on high-byte write
// - level control off: channel gain taken from manual field
// - periodic timing: gain reductions every suppression step period, increases at crossing or timeout
// - crossing timing: gain steps at first crossing or on timeout
// - right gain follows own or left crossings, per source select
// - crossing timeout of 384, 768, 3072 or 24576 samples
// - recovery and suppression thresholds in 1 dB steps
// - below recovery only after holding under threshold for hold time
// - common mode: either channel suppresses, left crossings used
// - periodic timing: suppression steps every 2, 4, 8 or 16 samples
// - third radio data block offset is C or C-prime
// - radio data sent only while its enable bit is set
// - pass-through sends 26-bit blocks from storage unmodified
// - check-word mode adds check word to stored 16-bit data
// - 4-bit composite level trim, unity at code 8
// - tank capacitor readback mirrors setting or automatic value
// - writing 1010 0000 to soft reset restores all registers
package fm_tx_pkg;
  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [6:0] ADDR_CLOCK_SETUP = 7'h00;
  localparam logic [6:0] ADDR_RDS_B1_HI = 7'h03;
  localparam logic [6:0] ADDR_RDS_B1_LO = 7'h04;
  localparam logic [6:0] ADDR_RDS_LT_HI = 7'h05;
  localparam logic [6:0] ADDR_RDS_LT_LO = 7'h06;
  localparam logic [6:0] ADDR_TRIM_LO = 7'h07;
  localparam logic [6:0] ADDR_TRIM_HI = 7'h08;
  localparam logic [6:0] ADDR_DIV_LO = 7'h0a;
  localparam logic [6:0] ADDR_DIV_HI = 7'h0b;
  localparam logic [6:0] ADDR_ALC_CTL = 7'h0d;
  localparam logic [6:0] ADDR_ALC_REC = 7'h0e;
  localparam logic [6:0] ADDR_ALC_LIM = 7'h0f;
  localparam logic [6:0] ADDR_RDS_CTL = 7'h10;
  localparam logic [6:0] ADDR_COMP_TRIM = 7'h15;
  localparam logic [6:0] ADDR_TANK_CAP = 7'h70;
  localparam logic [6:0] ADDR_SOFT_RESET = 7'h7f;
  localparam logic [7:0] SOFT_RESET_PATTERN = 8'ha0;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_CLOCK_SETUP = 8'h02;
  localparam logic [7:0] RST_TRIM_LO = 8'h7e;
  localparam logic [4:0] RST_TRIM_HI = 5'h0e;
  localparam logic [15:0] RST_DIVIDER = 16'h23d3;
  localparam logic [7:0] RST_ALC_CTL = 8'h06;
  localparam logic [7:0] RST_COMP_TRIM = 8'h40;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int AUTO_LEVEL_ENABLE_BIT = 0;
  localparam int MAN_GAIN_LSB = 1;
  localparam int TIMING_SEL_BIT = 4;
  localparam int RIGHT_SRC_BIT = 5;
  localparam int TIMEOUT_LSB = 6;
  localparam int REC_LVL_LSB = 0;
  localparam int HOLD_LSB = 4;
  localparam int LINK_SEL_BIT = 7;
  localparam int LIM_LVL_LSB = 0;
  localparam int LIM_PERIOD_LSB = 4;
  localparam int ATTEN_BIT = 6;
  localparam int OFFSET_SEL_BIT = 7;
  localparam int RADIO_DATA_TX_ENABLE_BIT = 6;
  localparam int CHECKW_BIT = 7;
  localparam int COMP_TRIM_LSB = 3;

  // ----------------------------------------------------------------
  // gain codes and sample counts
  // ----------------------------------------------------------------
  localparam logic [2:0] GAIN_UNITY = 3'h3;
  localparam logic [2:0] GAIN_MAX = 3'h6;
  localparam logic [4:0] LIM_DB_BASE = 5'h03;
  localparam logic [4:0] REC_DB_BASE = 5'h05;
  localparam logic [14:0] SAMPLES_384 = 15'h0180;
  localparam logic [14:0] SAMPLES_768 = 15'h0300;
  localparam logic [14:0] SAMPLES_3072 = 15'h0c00;
  localparam logic [14:0] SAMPLES_24576 = 15'h6000;
  localparam logic [14:0] SAMPLES_2 = 15'h0002;

  // ----------------------------------------------------------------
  // radio data check word
  // ----------------------------------------------------------------
  localparam logic [9:0] CRC_POLY = 10'h1b9;
  localparam logic [9:0] OFS_A = 10'h0fc;
  localparam logic [9:0] OFS_B = 10'h198;
  localparam logic [9:0] OFS_C = 10'h168;
  localparam logic [9:0] OFS_CP = 10'h350;
  localparam logic [9:0] OFS_D = 10'h1b4;

  typedef enum logic [1:0] {
    PEND_NONE = 2'b00,
    PEND_SUPP = 2'b01,
    PEND_REC = 2'b10
  } pend_e;

  function automatic logic [14:0] sel_samples(input logic [1:0] code);
    case (code)
      2'h0: sel_samples = SAMPLES_384;
      2'h1: sel_samples = SAMPLES_768;
      2'h2: sel_samples = SAMPLES_3072;
      default: sel_samples = SAMPLES_24576;
    endcase
  endfunction

  // full-scale magnitude for a level of -db dBFS, db from 3 to 20
  function automatic logic [15:0] dbfs_level(input logic [4:0] db);
    case (db)
      5'h03: dbfs_level = 16'h5a9d;
      5'h04: dbfs_level = 16'h50c3;
      5'h05: dbfs_level = 16'h47fa;
      5'h06: dbfs_level = 16'h4027;
      5'h07: dbfs_level = 16'h392c;
      5'h08: dbfs_level = 16'h32f5;
      5'h09: dbfs_level = 16'h2d6b;
      5'h0a: dbfs_level = 16'h287a;
      5'h0b: dbfs_level = 16'h2413;
      5'h0c: dbfs_level = 16'h2027;
      5'h0d: dbfs_level = 16'h1ca8;
      5'h0e: dbfs_level = 16'h198a;
      5'h0f: dbfs_level = 16'h16c3;
      5'h10: dbfs_level = 16'h1449;
      5'h11: dbfs_level = 16'h1215;
      5'h12: dbfs_level = 16'h101d;
      5'h13: dbfs_level = 16'h0e5d;
      default: dbfs_level = 16'h0ccd;
    endcase
  endfunction

  function automatic logic [9:0] check_bits(input logic [15:0] data);
    logic [9:0] r;
    logic fb;
    r = 10'h000;
    for (int i = 15; i >= 0; i--) begin
      fb = data[i] ^ r[9];
      r = {r[8:0], 1'b0};
      if (fb) begin
        r = r ^ CRC_POLY;
      end
    end
    check_bits = r;
  endfunction
endpackage

// >>> fm_host_model.sv
// host side of the register port: byte writes and registered reads
// assumes inputs of the bank are sampled on the rising clock edge
`timescale 1ns/1ps
module fm_host_model (
  input wire logic clk_sys,
  input wire logic [7:0] regRdData,
  output logic regWrEn,
  output logic [6:0] regAddr,
  output logic [7:0] regWrData
);
  initial begin
    regWrEn = 1'b0;
    regAddr = 7'h7e;
    regWrData = 8'h00;
  end
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    regWrEn = 1'b1;
    regAddr = a;
    regWrData = d;
    @(negedge clk_sys);
    regWrEn = 1'b0;
    regWrData = ~d;
  endtask
  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    @(negedge clk_sys);
    regAddr = a;
    @(negedge clk_sys);
    d = regRdData;
  endtask
  // low byte all ones while the high byte moves
  task automatic trim(input logic [12:0] w);
    wr(7'h07, 8'hff);
    wr(7'h08, {3'h0, w[12:8]});
    wr(7'h07, w[7:0]);
  endtask
endmodule

// >>> fm_tx_control_regs_alc_assertions.sv
// port checker for the control bank
// assumes it is bound onto the bank top module
`timescale 1ns/1ps
module fm_tx_control_regs_alc_chk (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic regWrEn,
  input wire logic [6:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic [7:0] regRdData,
  input wire logic sampleStrobe,
  input wire logic [7:0] tankCapSetting,
  input wire logic autoTuneActive,
  input wire logic [7:0] autoTankCap,
  input wire logic rdsBlockReq,
  input wire logic [7:0] clockSetup,
  input wire logic [12:0] vcoTrimWord,
  input wire logic [15:0] synthDivider,
  input wire logic [2:0] leftChannelGain,
  input wire logic radioDataTxEnable,
  input wire logic [25:0] rdsBlockWord,
  input wire logic [1:0] rdsBlockIndex
);
  logic [7:0] wrData_ff;
  logic [7:0] nxt_wrData;
  always_comb nxt_wrData = regWrData;
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) wrData_ff <= 8'h00;
    else wrData_ff <= nxt_wrData;
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  chk_div_stage: assert property (
    regWrEn && regAddr == 7'h0a |=> $stable(synthDivider))
    else $error("divider moved on low byte write");
  chk_div_load: assert property (
    regWrEn && regAddr == 7'h0b |=> synthDivider[15:8] == wrData_ff)
    else $error("divider high byte not loaded");
  chk_trim_low: assert property (
    regWrEn && regAddr == 7'h07 |=> vcoTrimWord[7:0] == wrData_ff)
    else $error("trim low byte not applied");
  chk_trim_high: assert property (
    regWrEn && regAddr == 7'h08 |=> vcoTrimWord[12:8] == wrData_ff[4:0])
    else $error("trim high bits not applied");
  chk_manual_gain: assert property (
    regWrEn && regAddr == 7'h0d && !regWrData[0] && regWrData[3:1] != 3'h7
    |=> leftChannelGain == wrData_ff[3:1])
    else $error("manual gain not taken");
  chk_gain_steady: assert property (
    (!sampleStrobe && !regWrEn)[*2] |=> $stable(leftChannelGain))
    else $error("gain moved without a sample");
  chk_rds_hold: assert property (
    rdsBlockReq && !radioDataTxEnable && !regWrEn
    |=> rdsBlockIndex == 2'd0 && $stable(rdsBlockWord))
    else $error("block sent while disabled");
  chk_rds_index: assert property (
    rdsBlockReq && radioDataTxEnable && !regWrEn
    |=> rdsBlockIndex == $past(rdsBlockIndex) + 2'd1)
    else $error("block index did not advance");
  chk_tank_read: assert property (
    regAddr == 7'h70 |=> regRdData == ($past(autoTuneActive) ?
    $past(autoTankCap) : $past(tankCapSetting)))
    else $error("tank readback wrong");
  chk_soft_reset: assert property (
    regWrEn && regAddr == 7'h7f && regWrData == 8'ha0 |=>
    clockSetup == 8'h02 && synthDivider == 16'h23d3 &&
    vcoTrimWord == 13'h0e7e && rdsBlockIndex == 2'd0)
    else $error("soft reset incomplete");
  cover property (regWrEn && regAddr == 7'h7f && regWrData == 8'ha0);
  cover property (rdsBlockReq && radioDataTxEnable);
  cover property (sampleStrobe ##1 $changed(leftChannelGain));
endmodule
bind fm_tx_control_regs_alc fm_tx_control_regs_alc_chk i_chk (.clk_sys,
  .rst_b, .regWrEn, .regAddr, .regWrData, .regRdData, .sampleStrobe,
  .tankCapSetting, .autoTuneActive, .autoTankCap, .rdsBlockReq, .clockSetup,
  .vcoTrimWord, .synthDivider, .leftChannelGain, .radioDataTxEnable,
  .rdsBlockWord, .rdsBlockIndex);

// >>> fm_tx_control_regs_alc_tb.sv
// self-checking bench for the control bank
// assumes the host model drives the register port
`timescale 1ns/1ps
module fm_tx_control_regs_alc_tb;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic regWrEn;
  logic [6:0] regAddr;
  logic [7:0] regWrData;
  logic [7:0] regRdData;
  logic sampleStrobe = 1'b0;
  logic [15:0] leftSmp = 16'h0000;
  logic [15:0] rightSmp = 16'h0000;
  logic autoTuneActive = 1'b0;
  logic rdsBlockReq = 1'b0;
  logic [7:0] clockSetup;
  logic [12:0] vcoTrimWord;
  logic [15:0] synthDivider;
  logic [2:0] leftGain;
  logic [2:0] rightGain;
  logic [3:0] compTrim;
  logic rdsEn;
  logic [25:0] rdsWord;
  logic [1:0] rdsIdx;
  logic [7:0] rdv;
  logic [9:0] ofs [4];
  int n_fail = 0;
  int cmp_count = 0;
  int cycles = 0;
  always #5 clk_sys = ~clk_sys;
  fm_host_model i_host (.clk_sys, .regRdData, .regWrEn, .regAddr, .regWrData);
  fm_tx_control_regs_alc i_dut (.clk_sys, .rst_b, .regWrEn, .regAddr,
    .regWrData, .regRdData, .sampleStrobe, .leftChannelSamples(leftSmp),
    .rightChannelSamples(rightSmp), .tankCapSetting(8'h5a), .autoTuneActive,
    .autoTankCap(8'ha5), .rdsBlockReq, .clockSetup, .vcoTrimWord, .synthDivider,
    .leftChannelGain(leftGain), .rightChannelGain(rightGain),
    .inputAttenuate(), .compositeLevelTrim(compTrim),
    .radioDataTxEnable(rdsEn), .rdsBlockWord(rdsWord), .rdsBlockIndex(rdsIdx));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic finish_test();
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic tick(input logic [15:0] s, input int n);
    leftSmp = s;
    rightSmp = s;
    repeat (n) begin
      @(negedge clk_sys);
      sampleStrobe = 1'b1;
      @(negedge clk_sys);
      sampleStrobe = 1'b0;
    end
  endtask
  task automatic req();
    @(negedge clk_sys);
    rdsBlockReq = 1'b1;
    @(negedge clk_sys);
    rdsBlockReq = 1'b0;
  endtask
  task automatic initVals();
    chk(clockSetup, 8'h02);
    chk(vcoTrimWord, 13'h0e7e);
    chk(synthDivider, 16'h23d3);
    chk(leftGain, 3'h3);
  endtask
  // own check word, generator x^10+x^8+x^7+x^5+x^4+x^3+1
  function automatic logic [9:0] crc(input logic [15:0] d);
    logic [9:0] r;
    r = 10'h000;
    for (int i = 15; i >= 0; i--)
      r = {r[8:0], 1'b0} ^ ((d[i] ^ r[9]) ? 10'h1b9 : 10'h000);
    return r;
  endfunction
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      finish_test();
    end
  end
  initial begin
    ofs = '{fm_tx_pkg::OFS_A, fm_tx_pkg::OFS_B, fm_tx_pkg::OFS_C,
      fm_tx_pkg::OFS_D};
    repeat (2) @(negedge clk_sys);
    rst_b = 1'b1;
    initVals();
    i_host.wr(7'h0a, 8'h34);
    chk(synthDivider, 16'h23d3);
    i_host.wr(7'h0b, 8'h12);
    chk(synthDivider, 16'h1234);
    i_host.trim(13'h0100);
    chk(vcoTrimWord, 13'h0100);
    i_host.rd(7'h08, rdv);
    chk(rdv, 8'h01);
    i_host.trim(13'h029e);
    chk(vcoTrimWord, 13'h029e);
    for (int g = 0; g < 7; g++) begin
      i_host.wr(7'h0d, {4'h0, g[2:0], 1'b0});
      chk(leftGain, g[2:0]);
      chk(rightGain, g[2:0]);
    end
    i_host.wr(7'h15, 8'h78);
    chk(compTrim, 4'hf);
    i_host.rd(7'h70, rdv);
    chk(rdv, 8'h5a);
    autoTuneActive = 1'b1;
    i_host.rd(7'h70, rdv);
    chk(rdv, 8'ha5);
    i_host.wr(7'h0f, 8'h00);
    i_host.wr(7'h0d, 8'h01);
    tick(16'h7000, 3);
    chk(leftGain, 3'h2);
    chk(rightGain, 3'h2);
    i_host.wr(7'h7f, 8'ha0);
    initVals();
    i_host.wr(7'h0d, 8'h11);
    tick(16'h7000, 2);
    chk(leftGain, 3'h3);
    tick(16'h9000, 1);
    chk(rightGain, 3'h2);
    tick(16'h9000, 380);
    chk(leftGain, 3'h2);
    tick(16'h9000, 6);
    chk(leftGain, 3'h1);
    i_host.wr(7'h0e, 8'h80);
    chk(rightGain, 3'h3);
    i_host.wr(7'h03, 8'h12);
    i_host.wr(7'h04, 8'h34);
    i_host.wr(7'h05, 8'h56);
    i_host.wr(7'h06, 8'hc0);
    req();
    chk(rdsIdx, 2'h0);
    i_host.wr(7'h10, 8'hc0);
    chk(rdsEn, 1'b1);
    for (int i = 0; i < 7; i++) begin
      if (i == 4) i_host.wr(7'h0f, 8'h80);
      req();
      if (i == 6) chk(rdsWord, {16'h56c0, crc(16'h56c0) ^ 10'h350});
      else if (i % 4 == 0) chk(rdsWord, {16'h1234, crc(16'h1234) ^ ofs[0]});
      else chk(rdsWord, {16'h56c0, crc(16'h56c0) ^ ofs[i % 4]});
    end
    i_host.wr(7'h10, 8'h40);
    req();
    chk(rdsWord, {24'h123456, 2'b11});
    finish_test();
  end
endmodule
